//--- pkg/dcum_pkg.sv
// shared constants and types for the mode-controlled down-counter
package dcum_pkg;

   // datapath widths
   localparam int unsigned CNT_W  = 16;
   localparam int unsigned MODE_W = 3;

   // field positions inside the synchronised pin bundle
   localparam int unsigned PIN_LOAD_LSB = 0;
   localparam int unsigned PIN_MODE_LSB = 16;
   localparam int unsigned PIN_TRIG     = 19;
   localparam int unsigned PIN_WR_N     = 20;
   localparam int unsigned PIN_CLR_N    = 21;
   localparam int unsigned PIN_W        = 22;

   // mode codes as decoded from function_select
   localparam logic [MODE_W-1:0] MODE_LEVEL     = 3'h0;
   localparam logic [MODE_W-1:0] MODE_LEVEL_INV = 3'h1;
   localparam logic [MODE_W-1:0] MODE_PULSE     = 3'h2;
   localparam logic [MODE_W-1:0] MODE_PULSE_INV = 3'h3;
   localparam logic [MODE_W-1:0] MODE_HOLD      = 3'h4;
   localparam logic [MODE_W-1:0] MODE_HOLD_INV  = 3'h5;
   localparam logic [MODE_W-1:0] MODE_ONESHOT   = 3'h6;
   localparam logic [MODE_W-1:0] MODE_FREQ      = 3'h7;

   // reset values
   localparam logic [CNT_W-1:0]  CNT_RST   = 16'h0000;
   localparam logic [CNT_W-1:0]  CNT_ONE   = 16'h0001;
   localparam logic [PIN_W-1:0]  PIN_RST   = 22'h300000;
   localparam logic [CNT_W-1:0]  LATCH_RST = 16'h0000;

   // behaviour classes of the eight modes
   typedef enum logic [2:0] {
      DCUM_LEVEL,
      DCUM_PULSE,
      DCUM_HOLD,
      DCUM_ONESHOT,
      DCUM_FREQ
   } dcum_class_t;

   // counter sequencing
   typedef enum logic [1:0] {
      DCUM_IDLE,
      DCUM_LOADED,
      DCUM_COUNTING
   } dcum_phase_t;

endpackage

//--- pkg/dcum_if.sv
`timescale 1ns/1ps
`default_nettype none
// synchronised controls from the pin front end to the counter core
interface dcum_if;
   logic                          trig;      // trigger, synchronised
   logic [dcum_pkg::MODE_W-1:0]   mode;      // function select, synchronised
   logic [dcum_pkg::CNT_W-1:0]    latch_val; // load value held by the latches
   logic                          clear_n;   // master clear, synchronised

   modport src (output trig, output mode, output latch_val, output clear_n);
   modport snk (input trig, input mode, input latch_val, input clear_n);
endinterface
`default_nettype wire

//--- src/dcum_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dcum_pin_sync (
   input  wire logic                        ref_clk_in,        // core clock
   input  wire logic                        rstn_in,           // sync reset, active low
   input  wire logic                        trigger_input_in,  // trigger pin
   input  wire logic [dcum_pkg::MODE_W-1:0] function_select_in,// mode pins
   input  wire logic [dcum_pkg::CNT_W-1:0]  load_value_in,     // data pins
   input  wire logic                        latch_write_n_in,  // latch write, active low
   input  wire logic                        clear_all_n_in,    // master clear pin
   dcum_if.src                              ctl                // synchronised controls
);

   typedef struct packed {
      logic [dcum_pkg::PIN_W-1:0] s1;    // first synchroniser stage
      logic [dcum_pkg::PIN_W-1:0] s2;    // second synchroniser stage
      logic [dcum_pkg::CNT_W-1:0] latch; // load-value latches
   } dcum_sync_t;

   dcum_sync_t st_reg;
   dcum_sync_t st_next;

   // s1 feeds only s2; every decision below looks at s2
   always_comb begin
      st_next    = st_reg;
      st_next.s1 = {clear_all_n_in, latch_write_n_in, trigger_input_in, function_select_in, load_value_in};
      st_next.s2 = st_reg.s1;
      if (!st_reg.s2[dcum_pkg::PIN_WR_N]) begin
         st_next.latch = st_reg.s2[dcum_pkg::PIN_LOAD_LSB +: dcum_pkg::CNT_W];
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         st_reg <= '{s1: dcum_pkg::PIN_RST, s2: dcum_pkg::PIN_RST, latch: dcum_pkg::LATCH_RST};
      end else begin
         st_reg <= st_next;
      end
   end

   assign ctl.trig      = st_reg.s2[dcum_pkg::PIN_TRIG];
   assign ctl.mode      = st_reg.s2[dcum_pkg::PIN_MODE_LSB +: dcum_pkg::MODE_W];
   assign ctl.clear_n   = st_reg.s2[dcum_pkg::PIN_CLR_N];
   assign ctl.latch_val = st_reg.latch;

endmodule
`default_nettype wire

//--- src/dcum_top.sv
// Notes on behaviour
// - inverted hold mode: output rests high, low for one clock at zero
// - inverted hold mode: divided output toggles as primary output falls
// - one-shot and frequency modes: trigger high loads latches every edge
// - one-shot and frequency modes: trigger fall starts decrement next edge
// - one-shot: output rests low, rises on the first decrement edge
// - one-shot: at zero output returns low and divided output toggles
// - one-shot: trigger during countdown reloads without touching the output
// - one-shot: high pulse lasts N-1 clocks for loaded value N
// - frequency mode: at terminal count output high one clock, divided output toggles
// - frequency mode: terminal edge also reloads counter from latches
// - frequency mode: decrementing resumes on the edge after reload
// - frequency mode: runs forever after one trigger until master clear
// - frequency mode: trigger high reloads counter and clears output
// - select inputs decode as a binary mode number zero to seven
// - load latches transparent while write low, hold after it rises
// - hold modes: trigger freezes count; no reload until zero reached
// - only mode seven reloads by itself; others need a trigger pulse
`timescale 1ns/1ps
`default_nettype none
module dcum_top (
   input  wire logic                        ref_clk_in,         // core clock, 125 MHz
   input  wire logic                        rstn_in,            // sync reset, active low
   input  wire logic                        trigger_input_in,   // load/count select pin
   input  wire logic [dcum_pkg::MODE_W-1:0] function_select_in, // mode select pins
   input  wire logic [dcum_pkg::CNT_W-1:0]  load_value_in,      // load value pins
   input  wire logic                        latch_write_n_in,   // latch write, active low
   input  wire logic                        clear_all_n_in,     // master clear, active low
   output logic                             q_out,              // primary output
   output logic                             q_div2_out,         // primary divided by two
   output logic [dcum_pkg::CNT_W-1:0]       count_out,          // live counter value
   output logic                             counting_out        // countdown in progress
);

   dcum_if ctl ();

   // pin synchronisers and load latches
   dcum_pin_sync i_dcum_pin_sync (
      .ref_clk_in         (ref_clk_in),
      .rstn_in            (rstn_in),
      .trigger_input_in   (trigger_input_in),
      .function_select_in (function_select_in),
      .load_value_in      (load_value_in),
      .latch_write_n_in   (latch_write_n_in),
      .clear_all_n_in     (clear_all_n_in),
      .ctl                (ctl)
   );

   typedef struct packed {
      dcum_pkg::dcum_phase_t      phase;  // sequencing of the counter
      logic [dcum_pkg::CNT_W-1:0] cnt;    // down-counter
      logic                       active; // output asserted, before polarity
      logic                       q;      // primary output level
      logic                       q2;     // divided output level
   } dcum_state_t;

   dcum_state_t st_reg;
   dcum_state_t st_next;

   // binary mode decode into behaviour classes
   function automatic dcum_pkg::dcum_class_t mode_class(input logic [dcum_pkg::MODE_W-1:0] m);
      dcum_pkg::dcum_class_t c;
      c = dcum_pkg::DCUM_LEVEL;
      case (m)
         dcum_pkg::MODE_LEVEL,
         dcum_pkg::MODE_LEVEL_INV: begin
            c = dcum_pkg::DCUM_LEVEL;
         end
         dcum_pkg::MODE_PULSE,
         dcum_pkg::MODE_PULSE_INV: begin
            c = dcum_pkg::DCUM_PULSE;
         end
         dcum_pkg::MODE_HOLD,
         dcum_pkg::MODE_HOLD_INV: begin
            c = dcum_pkg::DCUM_HOLD;
         end
         dcum_pkg::MODE_ONESHOT: begin
            c = dcum_pkg::DCUM_ONESHOT;
         end
         dcum_pkg::MODE_FREQ: begin
            c = dcum_pkg::DCUM_FREQ;
         end
         default: begin
            c = dcum_pkg::DCUM_LEVEL;
         end
      endcase
      return c;
   endfunction

   // odd modes below six drive the output inverted
   function automatic logic mode_inverted(input logic [dcum_pkg::MODE_W-1:0] m);
      logic inv;
      inv = 1'b0;
      case (m)
         dcum_pkg::MODE_LEVEL_INV,
         dcum_pkg::MODE_PULSE_INV,
         dcum_pkg::MODE_HOLD_INV: begin
            inv = 1'b1;
         end
         default: begin
            inv = 1'b0;
         end
      endcase
      return inv;
   endfunction

   // per-mode behaviour flags, so the next-state logic never compares mode codes itself
   typedef struct packed {
      logic one_clock;  // active level lasts a single clock
      logic hold;       // trigger during a countdown only pauses it
      logic keep_q;     // a reload leaves the output as it stands
      logic start_high; // output rises when decrementing starts
   } dcum_attr_t;

   // binary select code to behaviour flags
   function automatic dcum_attr_t mode_attr(input logic [dcum_pkg::MODE_W-1:0] m);
      dcum_attr_t a;
      a = '0;
      case (m)
         // level output, rests low
         dcum_pkg::MODE_LEVEL: begin
            a.one_clock  = 1'b0;
            a.hold       = 1'b0;
            a.keep_q     = 1'b0;
            a.start_high = 1'b0;
         end
         // level output, rests high
         dcum_pkg::MODE_LEVEL_INV: begin
            a.one_clock  = 1'b0;
            a.hold       = 1'b0;
            a.keep_q     = 1'b0;
            a.start_high = 1'b0;
         end
         // single-clock pulse at zero
         dcum_pkg::MODE_PULSE: begin
            a.one_clock  = 1'b1;
            a.hold       = 1'b0;
            a.keep_q     = 1'b0;
            a.start_high = 1'b0;
         end
         // single-clock pulse at zero, inverted
         dcum_pkg::MODE_PULSE_INV: begin
            a.one_clock  = 1'b1;
            a.hold       = 1'b0;
            a.keep_q     = 1'b0;
            a.start_high = 1'b0;
         end
         // pulse at zero, trigger freezes the count
         dcum_pkg::MODE_HOLD: begin
            a.one_clock  = 1'b1;
            a.hold       = 1'b1;
            a.keep_q     = 1'b0;
            a.start_high = 1'b0;
         end
         // pulse at zero, inverted, trigger freezes the count
         dcum_pkg::MODE_HOLD_INV: begin
            a.one_clock  = 1'b1;
            a.hold       = 1'b1;
            a.keep_q     = 1'b0;
            a.start_high = 1'b0;
         end
         // retriggerable one-shot: reload must not cut the pulse short
         dcum_pkg::MODE_ONESHOT: begin
            a.one_clock  = 1'b0;
            a.hold       = 1'b0;
            a.keep_q     = 1'b1;
            a.start_high = 1'b1;
         end
         // free-running generator, single-clock pulse per period
         dcum_pkg::MODE_FREQ: begin
            a.one_clock  = 1'b1;
            a.hold       = 1'b0;
            a.keep_q     = 1'b0;
            a.start_high = 1'b0;
         end
         default: begin
            a = '0;
         end
      endcase
      return a;
   endfunction

   dcum_pkg::dcum_class_t cls;
   dcum_attr_t            attr;
   logic                  inv;
   logic                  one_clock;
   logic                  terminal;
   logic                  frozen;

   // shared decode of the current mode and counter
   always_comb begin
      cls       = mode_class(ctl.mode);
      attr      = mode_attr(ctl.mode);
      inv       = mode_inverted(ctl.mode);
      one_clock = attr.one_clock;
      terminal  = (st_reg.cnt == dcum_pkg::CNT_ONE);
      // a hold-mode countdown ignores the trigger except to pause
      frozen    = attr.hold && (st_reg.phase == dcum_pkg::DCUM_COUNTING) &&
                  (st_reg.cnt != dcum_pkg::CNT_RST);
   end

   // next state of the counter and outputs
   always_comb begin
      st_next = st_reg;
      // pulse classes hold the active level one clock only
      if (one_clock) begin
         st_next.active = 1'b0;
      end
      if (ctl.trig) begin
         if (frozen) begin
            // count held where it stood, no reload
            st_next.cnt = st_reg.cnt;
         end else begin
            // trigger high loads the latched value
            st_next.cnt   = ctl.latch_val;
            st_next.phase = dcum_pkg::DCUM_LOADED;
            // one-shot reload leaves the output alone
            if (attr.keep_q) begin
               st_next.active = st_reg.active;
            end else begin
               st_next.active = 1'b0;
            end
         end
      end else begin
         case (st_reg.phase)
            dcum_pkg::DCUM_IDLE: begin
               // idle until a fresh trigger pulse
               st_next.phase = dcum_pkg::DCUM_IDLE;
            end
            dcum_pkg::DCUM_LOADED,
            dcum_pkg::DCUM_COUNTING: begin
               if (st_reg.cnt == dcum_pkg::CNT_RST) begin
                  // a zero load idles the counter
                  st_next.phase = dcum_pkg::DCUM_IDLE;
               end else begin
                  // trigger fall arms, decrement on this edge
                  st_next.phase = dcum_pkg::DCUM_COUNTING;
                  st_next.cnt   = st_reg.cnt - dcum_pkg::CNT_ONE;
                  // one-shot output rises as decrementing starts
                  if (attr.start_high && (st_reg.phase == dcum_pkg::DCUM_LOADED)) begin
                     st_next.active = 1'b1;
                  end
                  if (terminal) begin
                     // divided output toggles here, with the rise of the active pulse or, in one-shot, its fall
                     st_next.q2 = ~st_reg.q2;
                     case (cls)
                        dcum_pkg::DCUM_ONESHOT: begin
                           // output was high from first decrement to here
                           st_next.active = 1'b0;
                           st_next.phase  = dcum_pkg::DCUM_IDLE;
                        end
                        dcum_pkg::DCUM_FREQ: begin
                           st_next.active = 1'b1;
                           st_next.cnt    = ctl.latch_val;
                           st_next.phase  = dcum_pkg::DCUM_COUNTING;
                        end
                        default: begin
                           // level, pulse and hold classes assert at zero
                           st_next.active = 1'b1;
                           st_next.phase  = dcum_pkg::DCUM_IDLE;
                        end
                     endcase
                  end
               end
            end
            default: begin
               st_next.phase = dcum_pkg::DCUM_IDLE;
            end
         endcase
      end
      // polarity applied once, output stays a flip-flop
      st_next.q = st_next.active ^ inv;
      // master clear returns everything to rest
      if (!ctl.clear_n) begin
         st_next.phase  = dcum_pkg::DCUM_IDLE;
         st_next.cnt    = dcum_pkg::CNT_RST;
         st_next.active = 1'b0;
         st_next.q2     = 1'b0;
         st_next.q      = inv;
      end
   end

   // single state register; reset values are constants only
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         st_reg <= '{phase:  dcum_pkg::DCUM_IDLE,
                     cnt:    dcum_pkg::CNT_RST,
                     active: 1'b0,
                     q:      1'b0,
                     q2:     1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state register
   assign q_out        = st_reg.q;
   assign q_div2_out   = st_reg.q2;
   assign count_out    = st_reg.cnt;
   assign counting_out = (st_reg.phase == dcum_pkg::DCUM_COUNTING);

endmodule
`default_nettype wire

//--- verification/dcum_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module dcum_top_props (
   input wire logic                        ref_clk_in,         // core clock
   input wire logic                        rstn_in,            // sync reset, active low
   input wire logic                        trigger_input_in,   // trigger pin
   input wire logic [dcum_pkg::MODE_W-1:0] function_select_in, // mode pins
   input wire logic                        clear_all_n_in,     // master clear pin
   input wire logic                        q_out,              // primary output
   input wire logic                        q_div2_out,         // divided output
   input wire logic [dcum_pkg::CNT_W-1:0]  count_out,          // counter value
   input wire logic                        counting_out        // countdown flag
);
   logic [2:0]  trig_d; // trigger pin history
   logic [2:0]  clr_d;  // clear pin history
   logic [11:0] mode_d; // four stages of mode pins
   logic [2:0]  md3;    // mode the core acts on
   logic        tr3;    // trigger the core acts on
   logic        cl3;    // clear the core acts on
   logic        mst;    // mode steady, no clear
   // mirror the pin synchroniser so checks see what the core sees
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         trig_d <= 3'h0;
         clr_d  <= 3'h7;
         mode_d <= 12'h000;
      end else begin
         trig_d <= {trig_d[1:0], trigger_input_in};
         clr_d  <= {clr_d[1:0], clear_all_n_in};
         mode_d <= {mode_d[8:0], function_select_in};
      end
   end
   // a mode change mid-count is undefined, so checks wait for a steady mode
   assign md3 = mode_d[8:6];
   assign tr3 = trig_d[2];
   assign cl3 = clr_d[2];
   assign mst = (mode_d[11:9] == md3) && cl3;
   default clocking dcb @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   AST_CLEAR: assert property (!cl3 |-> count_out == 16'h0000 && !q_div2_out && !counting_out
      && q_out == (md3[0] && md3 != 3'h7)) else $error("clear did not reach rest state");
   AST_HOLD_INV: assert property (md3 == 3'h5 && mst && $fell(q_out) |-> $past(count_out) == 16'h0001
      && count_out == 16'h0000 && q_div2_out != $past(q_div2_out) ##1 q_out) else $error("inverted pulse wrong");
   AST_HOLD_FREEZE: assert property (md3 == 3'h5 && mst && tr3 && $past(count_out) != 16'h0000
      |-> $stable(count_out)) else $error("held count moved");
   AST_SHOT_START: assert property (md3 == 3'h6 && mst && !tr3 && $past(tr3) && $past(count_out) > 16'h0001
      |-> q_out && count_out == $past(count_out) - 16'h0001) else $error("one-shot start wrong");
   AST_SHOT_RETRIG: assert property (md3 == 3'h6 && mst && tr3 && $past(q_out) |-> q_out)
      else $error("retrigger disturbed output");
   AST_SHOT_END: assert property (md3 == 3'h6 && mst && $fell(q_out) |-> $past(count_out) == 16'h0001
      && count_out == 16'h0000 && q_div2_out != $past(q_div2_out)) else $error("one-shot end wrong");
   AST_FREQ_TERM: assert property (md3 == 3'h7 && mst && $rose(q_out) |-> $past(count_out) == 16'h0001
      && count_out != 16'h0000 && q_div2_out != $past(q_div2_out) ##1 !q_out) else $error("frequency pulse wrong");
   AST_FREQ_RUN: assert property (md3 == 3'h7 && mst && !tr3 && $past(count_out) > 16'h0001
      |-> count_out == $past(count_out) - 16'h0001) else $error("frequency count stalled");
   AST_FREQ_TRIG: assert property (md3 == 3'h7 && mst && tr3 |-> !q_out
      && (!$past(tr3) || $stable(count_out))) else $error("trigger load wrong");
endmodule
bind dcum_top dcum_top_props i_dcum_top_props (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
   .trigger_input_in(trigger_input_in), .function_select_in(function_select_in),
   .clear_all_n_in(clear_all_n_in), .q_out(q_out), .q_div2_out(q_div2_out),
   .count_out(count_out), .counting_out(counting_out));
`default_nettype wire

//--- verification/dcum_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcum_host_model (
   input  wire logic        ref_clk_in, // core clock
   output logic             trig_out,   // trigger pin
   output logic [2:0]       mode_out,   // mode pins
   output logic [15:0]      data_out,   // load value pins
   output logic             wr_n_out,   // latch write, active low
   output logic             clr_n_out   // master clear, active low
);
   // idle pins at time zero
   initial begin
      trig_out = 1'b0;
      mode_out = 3'h0;
      data_out = 16'hffff;
      wr_n_out = 1'b1;
      clr_n_out = 1'b1;
   end
   // binary mode code, changed only under clear
   task automatic set_mode(input logic [2:0] m);
      @(posedge ref_clk_in);
      clr_n_out <= 1'b0;
      mode_out <= m;
      repeat (6) @(posedge ref_clk_in);
      clr_n_out <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
   endtask
   // callers never load one in one-shot mode
   task automatic load(input logic [15:0] v);
      @(posedge ref_clk_in);
      data_out <= v;
      wr_n_out <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
      wr_n_out <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      data_out <= ~v; // bus released, no longer shows the value
      repeat (2) @(posedge ref_clk_in);
   endtask
   // each count cycle starts from a trigger pulse, except mode seven's own reloads
   task automatic pulse(input int n);
      @(posedge ref_clk_in);
      trig_out <= 1'b1;
      repeat (n) @(posedge ref_clk_in);
      trig_out <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- verification/tb_down_counter_upper_modes.sv
`timescale 1ns/1ps
`default_nettype none
module tb_down_counter_upper_modes;
   logic        ref_clk_in = 1'b0;
   logic        rstn_in = 1'b0;
   logic        trig, wr_n, clr_n, q, q2, cnting;
   logic [2:0]  mode;
   logic [15:0] data, cnt;
   logic [15:0] q_x, q2_x, run_x; // one-bit outputs widened for check
   int          n_fail = 0;
   int          n_tests = 0;
   always #4 ref_clk_in = ~ref_clk_in;
   dcum_host_model i_dcum_host_model (.ref_clk_in(ref_clk_in), .trig_out(trig), .mode_out(mode),
      .data_out(data), .wr_n_out(wr_n), .clr_n_out(clr_n));
   dcum_top i_dcum_top (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .trigger_input_in(trig),
      .function_select_in(mode), .load_value_in(data), .latch_write_n_in(wr_n), .clear_all_n_in(clr_n),
      .q_out(q), .q_div2_out(q2), .count_out(cnt), .counting_out(cnting));
   // widen once here so every check compares whole words
   assign q_x   = {15'h0000, q};
   assign q2_x  = {15'h0000, q2};
   assign run_x = {15'h0000, cnting};
   task automatic finish_test();
      if (n_fail == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // bounded wait, mid-cycle, for q (on_cnt low) or the count to reach v
   task automatic wait_sig(input bit on_cnt, input logic [15:0] v);
      int i;
      i = 0;
      @(negedge ref_clk_in);
      while ((on_cnt ? cnt : q_x) !== v && i < 300) begin
         @(negedge ref_clk_in);
         i++;
      end
      if (i == 300) begin
         n_fail++;
         finish_test();
      end
   endtask
   // count mid-cycle samples while q stays high
   task automatic run_high(output logic [15:0] n);
      n = 16'h0000;
      while (q === 1'b1 && n < 100) begin
         n++;
         @(negedge ref_clk_in);
      end
   endtask
   // free-running generator: period, reload, retrigger, then clear
   task automatic t_freq();
      logic [15:0] p2;
      logic [15:0] i;
      i_dcum_host_model.set_mode(3'h7);
      i_dcum_host_model.load(16'h0004);
      i_dcum_host_model.pulse(3);
      @(negedge ref_clk_in);
      check(cnt, 16'h0004);
      check(run_x, 16'h0000);
      wait_sig(0, 16'h0001);
      check(cnt, 16'h0004);
      p2 = q2_x;
      for (int k = 0; k < 2; k++) begin
         @(negedge ref_clk_in);
         check(q_x, 16'h0000);
         check(cnt, 16'h0003);
         check(run_x, 16'h0001);
         i = 16'h0001;
         while (q !== 1'b1 && i < 50) begin
            @(negedge ref_clk_in);
            i++;
         end
         check(i, 16'h0004);
         p2 = p2 ^ 16'h0001;
         check(q2_x, p2);
      end
      i_dcum_host_model.pulse(2);
      repeat (2) @(negedge ref_clk_in);
      check(q_x, 16'h0000);
      check(cnt, 16'h0004);
      i_dcum_host_model.set_mode(3'h6);
      @(negedge ref_clk_in);
      check(cnt, 16'h0000);
      check(q_x, 16'h0000);
      check(q2_x, 16'h0000);
      check(run_x, 16'h0000);
   endtask
   // one-shot: pulse length, then a retrigger that stretches it
   task automatic t_shot();
      logic [15:0] n;
      i_dcum_host_model.load(16'h0009);
      i_dcum_host_model.pulse(2);
      @(negedge ref_clk_in);
      check(q_x, 16'h0000);
      wait_sig(0, 16'h0001);
      check(cnt, 16'h0008);
      run_high(n);
      check(n, 16'h0008);
      check(q2_x, 16'h0001);
      i_dcum_host_model.pulse(2);
      wait_sig(0, 16'h0001);
      repeat (2) @(negedge ref_clk_in);
      i_dcum_host_model.pulse(1);
      wait_sig(1, 16'h0009);
      check(q_x, 16'h0001);
      run_high(n);
      check(n, 16'h0009);
      check(q2_x, 16'h0000);
   endtask
   // inverted count-hold: rest high, one low cycle, freeze on trigger
   task automatic t_hold();
      i_dcum_host_model.set_mode(3'h5);
      i_dcum_host_model.load(16'h0003);
      @(negedge ref_clk_in);
      check(q_x, 16'h0001);
      i_dcum_host_model.pulse(1);
      wait_sig(0, 16'h0000);
      check(cnt, 16'h0000);
      check(q2_x, 16'h0001);
      @(negedge ref_clk_in);
      check(q_x, 16'h0001);
      i_dcum_host_model.load(16'h0008);
      i_dcum_host_model.pulse(1);
      wait_sig(1, 16'h0006);
      i_dcum_host_model.pulse(4);
      @(negedge ref_clk_in);
      check(cnt, 16'h0003);
      wait_sig(0, 16'h0000);
   endtask
   initial begin
      repeat (12) @(posedge ref_clk_in);
      rstn_in <= 1'b1;
      t_freq();
      t_shot();
      t_hold();
      finish_test();
   end
endmodule
`default_nettype wire
